// *** hw/serial_dac_input_port.sv ***
// Serial input port of a multi-channel 10-bit converter: frame capture,
// data and output registers, load, clear and power-down control.
// Assumes the host shift clock is far slower than clk (several clk per half period).
//
// Summary of operation
// - Low frame sync enables shifting on falling shift clock edges; high sync ignores data.
// - A frame carries one 16-bit word, one bit per falling edge.
// - Falling load input copies every data register into its output register together.
// - Load low at the sixteenth edge, or tied low, updates outputs automatically.
// - Clear low forces outputs to the clear code and resets sub converters, unclocked.
// - Power-down low puts the device in low power; release returns normal operation.
// - A channel uses the external reference only when its select bit is set.
module serial_dac_input_port
   import dac_serial_pkg::*;
#(
   parameter int unsigned CHANNELS      = 8,
   parameter bit          CLEAR_SIXTEEN = 1'b0
) (
   input  wire logic                                 clk,
   input  wire logic                                 rst_n,
   input  wire logic                                 ce,
   input  wire logic                                 frame_sync_n,
   input  wire logic                                 serial_data_in,
   input  wire logic                                 shift_clock,
   input  wire logic                                 load_outputs_n,
   input  wire logic                                 async_clear_n,
   input  wire logic                                 power_down_n,
   output logic [CHANNELS-1:0][dac_serial_pkg::CODE_BITS-1:0] dac_code_q,
   output logic [CHANNELS-1:0]                       ext_ref_sel_q,
   output logic                                      low_power_q,
   output logic                                      sub_clear_q
);
   import dac_serial_pkg::*;

   localparam logic [9:0] CLEAR_CODE = CLEAR_SIXTEEN ? CLEAR_CODE_SIXTEEN : CLEAR_CODE_BIAS;

   logic [SYNC_PINS-1:0]                s1_q;
   logic [SYNC_PINS-1:0]                s2_q;
   logic [SYNC_PINS-1:0]                s3_q;
   logic [SYNC_PINS-1:0]                pin_q;
   logic [SYNC_PINS-1:0]                pin_d;
   logic                                sclk_prev_q;
   logic                                load_prev_q;
   logic                                sclk_fall;
   logic                                load_fall;
   logic                                frame_on;
   logic [WORD_BITS-1:0]                shift_q;
   logic [CNT_BITS-1:0]                 bit_count_q;
   logic                                take_bit;
   logic                                word_done;
   entry_t                              pend_q;
   logic                                pend_valid_q;
   logic                                buf_in_ready;
   logic                                buf_out_valid;
   logic                                buf_out_ready;
   entry_t                              buf_out;
   logic                                drain;
   logic                                chan_ok;
   logic [CHANNELS-1:0][CODE_BITS-1:0]  data_q;
   logic [CHANNELS-1:0][CODE_BITS-1:0]  data_next;
   logic                                clr_rst_n;

   // Three stages; a pin level counts only once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q  <= PINS_RESET;
         s2_q  <= PINS_RESET;
         s3_q  <= PINS_RESET;
         pin_q <= PINS_RESET;
      end else if (ce) begin
         s1_q  <= {power_down_n, load_outputs_n, shift_clock, serial_data_in, frame_sync_n};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         pin_q <= pin_d;
      end
   end

   assign pin_d = (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev_q <= 1'b1;
         load_prev_q <= 1'b1;
      end else if (ce) begin
         sclk_prev_q <= pin_q[PIN_SCLK];
         load_prev_q <= pin_q[PIN_LOAD];
      end
   end

   assign sclk_fall = sclk_prev_q && !pin_q[PIN_SCLK];
   assign load_fall = load_prev_q && !pin_q[PIN_LOAD];
   assign frame_on  = !pin_q[PIN_FRAME];
   assign take_bit  = frame_on && sclk_fall && (bit_count_q != BITS_FULL);
   assign word_done = take_bit && (bit_count_q == BITS_LAST);

   // Shift register and bit counter; the count rests at sixteen until sync rises
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q     <= '0;
         bit_count_q <= '0;
      end else if (ce) begin
         if (!frame_on) begin
            bit_count_q <= '0;
         end else if (take_bit) begin
            shift_q     <= {shift_q[WORD_BITS-2:0], pin_q[PIN_DATA]};
            bit_count_q <= bit_count_q + 1'b1;
         end
      end
   end

   // Finished word waits here for the buffer; a new word completing wins over the hand-off
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_valid_q <= 1'b0;
         pend_q       <= '0;
      end else if (ce) begin
         if (word_done) begin
            pend_valid_q     <= 1'b1;
            pend_q.word      <= word_t'({shift_q[WORD_BITS-2:0], pin_q[PIN_DATA]});
            pend_q.auto_load <= !pin_q[PIN_LOAD];
         end else if (buf_in_ready) begin
            pend_valid_q <= 1'b0;
         end
      end
   end

   // Draining stalls in power-down, so the buffer genuinely fills
   assign buf_out_ready = pin_q[PIN_PWR];

   word_buffer #(
      .WIDTH ($bits(entry_t)),
      .DEPTH (2)
   ) u_word_buffer (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (pend_valid_q),
      .in_ready  (buf_in_ready),
      .in_data   (pend_q),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out)
   );

   assign drain   = ce && buf_out_valid && buf_out_ready;
   assign chan_ok = (32'(buf_out.word.chan) < CHANNELS);

   always_comb begin
      data_next = data_q;
      if (drain && chan_ok) begin
         data_next[buf_out.word.chan] = buf_out.word.code;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q        <= {CHANNELS{DATA_RESET}};
         ext_ref_sel_q <= '0;
      end else if (drain && chan_ok) begin
         data_q                           <= data_next;
         ext_ref_sel_q[buf_out.word.chan] <= buf_out.word.ext_ref;
      end
   end

   // Clear acts without the clock, so it joins the reset of the output stage
   assign clr_rst_n = rst_n && async_clear_n;

   always_ff @(posedge clk or negedge clr_rst_n) begin
      if (!clr_rst_n) begin
         dac_code_q <= {CHANNELS{CLEAR_CODE}};
      end else if (ce && (load_fall || (drain && buf_out.auto_load))) begin
         dac_code_q <= data_next;
      end
   end

   always_ff @(posedge clk or negedge clr_rst_n) begin
      if (!clr_rst_n) begin
         sub_clear_q <= 1'b1;
      end else if (ce) begin
         sub_clear_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_power_q <= 1'b0;
      end else if (ce) begin
         low_power_q <= !pin_q[PIN_PWR];
      end
   end

   a_frame_gate: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !frame_on |=> bit_count_q == '0)
      else $error("bit count not held at zero outside a frame");

   a_sixteen_bits: assert property (@(posedge clk) disable iff (!rst_n)
      ce && word_done |=> pend_valid_q && bit_count_q == BITS_FULL
                          && pend_q.word == word_t'({$past(shift_q[WORD_BITS-2:0]), $past(pin_q[PIN_DATA])}))
      else $error("completed word not handed on after sixteen bits");

   a_load_copy: assert property (@(posedge clk) disable iff (!rst_n || !async_clear_n)
      ce && load_fall ##1 async_clear_n |-> dac_code_q == $past(data_next))
      else $error("load edge did not copy all data registers");

   a_auto_update: assert property (@(posedge clk) disable iff (!rst_n || !async_clear_n)
      drain && buf_out.auto_load ##1 async_clear_n |-> dac_code_q == $past(data_next))
      else $error("automatic update missing");

   a_clear_forces: assert property (@(posedge clk) disable iff (!rst_n)
      !async_clear_n |-> sub_clear_q && dac_code_q[0] == CLEAR_CODE && dac_code_q[CHANNELS-1] == CLEAR_CODE)
      else $error("clear did not force outputs");

   a_power_down: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !pin_q[PIN_PWR] |=> low_power_q && $stable(data_q) && $stable(ext_ref_sel_q))
      else $error("power-down not entered or words still applied");

   a_ref_select: assert property (@(posedge clk) disable iff (!rst_n)
      drain && chan_ok |=> ext_ref_sel_q[$past(buf_out.word.chan)] == $past(buf_out.word.ext_ref))
      else $error("reference select not stored for channel");

   a_extra_edges: assert property (@(posedge clk) disable iff (!rst_n)
      ce && frame_on && bit_count_q == BITS_FULL |=> $stable(shift_q) && !$rose(pend_valid_q))
      else $error("edge after sixteenth bit was taken");

endmodule // serial_dac_input_port

// *** hw/dac_serial_pkg.sv ***
// Shared types and constants of the serial converter input port.
// Assumes one system clock; all pins arrive unsynchronised.
package dac_serial_pkg;

   localparam int unsigned WORD_BITS  = 16;
   localparam int unsigned CODE_BITS  = 10;
   localparam int unsigned CHAN_BITS  = 3;
   localparam int unsigned CNT_BITS   = 5;
   localparam int unsigned SYNC_PINS  = 5;

   // Positions of the synchronised pins in the pin vector
   localparam int unsigned PIN_FRAME  = 0;
   localparam int unsigned PIN_DATA   = 1;
   localparam int unsigned PIN_SCLK   = 2;
   localparam int unsigned PIN_LOAD   = 3;
   localparam int unsigned PIN_PWR    = 4;

   // Counts at which a frame holds a complete word and takes its last bit
   localparam logic [4:0]  BITS_FULL  = 5'h10;
   localparam logic [4:0]  BITS_LAST  = 5'h0F;

   // Clear codes: mid scale is the bias level, the other one sixteenth of it; data registers reset to mid scale
   localparam logic [9:0]  CLEAR_CODE_BIAS    = 10'h200;
   localparam logic [9:0]  CLEAR_CODE_SIXTEEN = 10'h020;
   localparam logic [9:0]  DATA_RESET         = 10'h200;

   // Idle level of all pins after reset: strobes high, data low
   localparam logic [4:0]  PINS_RESET = 5'h1D;

   // Word layout: channel, reference select, two spare bits, code
   typedef struct packed {
      logic [2:0] chan;
      logic       ext_ref;
      logic [1:0] spare;
      logic [9:0] code;
   } word_t;

   typedef struct packed {
      logic  auto_load;
      word_t word;
   } entry_t;

endpackage : dac_serial_pkg

// *** hw/word_buffer.sv ***
// Small FIFO with valid and ready on both sides.
// Assumes the caller holds data stable while valid and not ready.
module word_buffer #(
   parameter int unsigned WIDTH = 17,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [PW:0]      fill_q;
   logic             push;
   logic             pop;

   assign in_ready  = (fill_q != (PW+1)'(DEPTH));
   assign out_valid = (fill_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = ce && in_valid && in_ready;
   assign pop       = ce && out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fill_q   <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            fill_q <= fill_q + 1'b1;
         end else if (pop && !push) begin
            fill_q <= fill_q - 1'b1;
         end
      end
   end

endmodule // word_buffer

// *** tb/host_frame_model.sv ***
// Host side of the serial link: frames words with sync, shift clock and data.
// Assumes the caller invokes send from a single process; pins change on falling clk.
module host_frame_model (
   input  wire logic clk,
   output logic      frame_sync_n,
   output logic      shift_clock,
   output logic      serial_data_in
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      frame_sync_n   = 1'b1;
      shift_clock    = 1'b1;
      serial_data_in = 1'b0;
   end

   // Each clock level lasts five clk, so the duty cycle is 50 percent
   task automatic send(input logic [19:0] bits, input int n, input bit framed);
      @(negedge clk);
      frame_sync_n <= !framed;
      repeat (5) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         serial_data_in <= bits[19-i];
         repeat (5) @(negedge clk);
         shift_clock <= 1'b0;
         repeat (5) @(negedge clk);
         shift_clock <= 1'b1;
      end
      repeat (5) @(negedge clk);
      frame_sync_n   <= 1'b1;
      // Released data line shows the inverse, never a stale bit
      serial_data_in <= !serial_data_in;
      repeat (5) @(negedge clk);
   endtask
endmodule // host_frame_model

// *** tb/test_serial_dac_input_port.sv ***
// Self-checking bench of the serial converter input port.
// Assumes host_frame_model drives the link; load, clear and power pins come from here.
module test_serial_dac_input_port;
   import dac_serial_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CH = 8;
   typedef logic [CH-1:0][CODE_BITS-1:0] codes_t;
   localparam codes_t CLR_V = {CH{CLEAR_CODE_BIAS}};
   logic          clk, rst_n, ce, fs_n, sd, sck, load_n, clr_n, pd_n, low_q, sub_q;
   codes_t        dac_q, seen, last_exp, data_m;
   codes_t        exp_q[$];
   logic [CH-1:0] ext_q, ext_m;
   logic [31:0]   rnd;
   int            err_count, comparisons;

   serial_dac_input_port #(.CHANNELS(CH)) dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .frame_sync_n(fs_n), .serial_data_in(sd),
      .shift_clock(sck), .load_outputs_n(load_n), .async_clear_n(clr_n),
      .power_down_n(pd_n), .dac_code_q(dac_q), .ext_ref_sel_q(ext_q),
      .low_power_q(low_q), .sub_clear_q(sub_q)
   );
   host_frame_model host (.clk(clk), .frame_sync_n(fs_n), .shift_clock(sck), .serial_data_in(sd));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic check_code(string n, codes_t e, codes_t s);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic check_bit(string n, logic [CH-1:0] e, logic [CH-1:0] s);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic stop_test();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Only real changes are queued, since the watcher reacts to changes alone
   task automatic expect_out(codes_t v);
      if (v !== last_exp) exp_q.push_back(v);
      last_exp = v;
   endtask

   task automatic drain();
      for (int i = 0; i < 80 && exp_q.size() > 0; i++) @(negedge clk);
      check_bit("pending results", '0, CH'(exp_q.size()));
   endtask

   task automatic word(input logic [2:0] ch, input logic ext, input logic [9:0] code, input int n);
      if (n >= 16) begin
         data_m[ch] = code;
         ext_m[ch]  = ext;
         if (!load_n) expect_out(data_m);
      end
      host.send({ch, ext, 2'b00, code, 4'h5}, n, 1'b1);
   endtask

   task automatic pulse_load();
      expect_out(data_m);
      load_n <= 1'b0;
      repeat (4) @(negedge clk);
      load_n <= 1'b1;
      drain();
   endtask

   always @(negedge clk) begin
      if (rst_n && dac_q !== seen) begin
         seen = dac_q;
         check_code("dac_code_q", exp_q.size() > 0 ? exp_q.pop_front() : last_exp, seen);
      end
   end

   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      stop_test();
   end

   initial begin
      {rst_n, ce, load_n, clr_n, pd_n} = 5'b01111;
      seen     = CLR_V;
      last_exp = CLR_V;
      data_m   = {CH{DATA_RESET}};
      ext_m    = '0;
      rnd      = 32'he197_d83d;
      repeat (5) @(negedge clk);
      check_code("reset dac_code_q", CLR_V, dac_q);
      check_bit("ext_ref_sel_q", ext_m, ext_q);
      check_bit("low_power_q sub_clear_q", 'h1, CH'({low_q, sub_q}));
      rst_n <= 1'b1;
      repeat (10) @(negedge clk);
      check_bit("low_power_q sub_clear_q", 'h0, CH'({low_q, sub_q}));
      word(3'd3, 1'b1, 10'h155, 16);
      pulse_load();
      ce     <= 1'b0;
      load_n <= 1'b0;
      repeat (6) @(negedge clk);
      load_n <= 1'b1;
      repeat (2) @(negedge clk);
      ce     <= 1'b1;
      repeat (8) @(negedge clk);
      check_code("dac_code_q frozen", data_m, dac_q);
      load_n <= 1'b0;
      host.send({16'hE3FF, 4'hF}, 16, 1'b0);
      word(3'd2, 1'b0, 10'h0AA, 10);
      for (int i = 0; i < CH; i++) begin
         rnd = xs(rnd);
         word(i[2:0], rnd[12], rnd[9:0], i == CH - 1 ? 20 : 16);
      end
      drain();
      check_bit("ext_ref_sel_q", ext_m, ext_q);
      load_n <= 1'b1;
      @(negedge clk);
      expect_out(CLR_V);
      clr_n <= 1'b0;
      #1 check_bit("sub_clear_q", 'h1, CH'(sub_q));
      check_code("dac_code_q at clear", CLR_V, dac_q);
      repeat (5) @(negedge clk);
      clr_n <= 1'b1;
      repeat (5) @(negedge clk);
      pulse_load();
      pd_n   <= 1'b0;
      load_n <= 1'b0;
      repeat (8) @(negedge clk);
      check_bit("low_power_q", 'h1, CH'(low_q));
      word(3'd5, 1'b0, ~data_m[5], 16);
      repeat (20) @(negedge clk);
      check_bit("held results", 'h1, CH'(exp_q.size()));
      pd_n <= 1'b1;
      drain();
      repeat (8) @(negedge clk);
      check_bit("low_power_q", 'h0, CH'(low_q));
      stop_test();
   end
endmodule // test_serial_dac_input_port
